// file: design/nsac_consts.svh
// constants for the non-secure access control register block
// assumes inclusion by bare name from design files only
`ifndef NSAC_CONSTS_SVH
`define NSAC_CONSTS_SVH
// coprocessor move encoding of this register
`define NSAC_OPC1 3'h0
`define NSAC_CRN 4'h1
`define NSAC_CRM 4'h1
`define NSAC_OPC2 3'h2
// field positions
`define NSAC_BIT_COH 18
`define NSAC_BIT_L2E 17
`define NSAC_BIT_VEC 15
`define NSAC_BIT_UPR 14
`define NSAC_BIT_COPROC_ELEVEN_NS_ENABLE 11
`define NSAC_BIT_COPROC_TEN_NS_ENABLE 10
// implemented writable bits and reset value
`define NSAC_WMASK 32'h0006CC00
`define NSAC_RESET 32'h00000000
// positions in the other registers that this block guards
`define NSAC_AUX_COH_BIT 6
`define NSAC_L2_ERR_BIT 29
`define NSAC_CPA_VEC_BIT 31
`define NSAC_CPA_UPR_BIT 30
`define NSAC_CPA_COPROC_TEN_NS_ENABLE_LSB 20
`define NSAC_CPA_COPROC_ELEVEN_NS_ENABLE_LSB 22
`endif

// file: design/nsac_pkg.sv
// types for the non-secure access control register block
// assumes nsac_consts.svh supplies the numeric constants
package nsac_pkg;
    // one coprocessor move request from the core
    typedef struct packed {
        logic valid;      // move instruction issued
        logic write;      // 1 move to coprocessor, 0 move from
        logic [2:0] opc1; // first opcode
        logic [3:0] crn;  // primary register
        logic [3:0] crm;  // secondary register
        logic [2:0] opc2; // second opcode
        logic [31:0] wdata; // write data
    } nsac_req_t;
    // processor context
    typedef struct packed {
        logic [1:0] priv;    // privilege level 0..2
        logic monitor;       // in monitor mode
        logic ns_bit;        // nonsecure_state_bit of secure_config_reg
    } nsac_ctx_t;
    // whole state of the block
    typedef struct packed {
        logic [31:0] ctl;    // nonsecure_access_control contents
        logic [31:0] rdata;  // read data
        logic rvalid;        // read answer strobe
        logic undef;         // access refused
    } nsac_state_t;
endpackage : nsac_pkg

// file: design/nsac_top.sv
// non-secure access control register and its guards on other registers
// assumes the core issues coprocessor moves synchronous to clock; context
// comes from logic on the same clock, so no synchronisers are needed
`timescale 1ns/10ps
`default_nettype none
`include "nsac_consts.svh"

// Summary of operation
// - no access below level one; nonsecure read-only
// - bit18 clear blocks nonsecure aux register writes
// - bit18 set lets nonsecure write coherency bit
// - bit17 clear blocks nonsecure l2 register writes
// - bit17 set lets nonsecure write error bit
// - bit15 set forces vector disable in nonsecure
// - bit14 set forces upper disable, ignores writes
// - fp without vector: bits 15,14 read one
// - no fp: bits 15,14 unknown, read zero
// - bit11 clear refuses nonsecure slot eleven access
// - bit10 clear refuses nonsecure slot ten access
// - disabled slot field reads 00, ignores writes
// - enabled slot accepts both security states
// - no fp: slot enable bits read zero
// - encoding opcode1 0, c1, c1, opcode2 2
// - secure state from ns bit, monitor secure
module nsac_top #(
    parameter bit HAS_FP = 1'b1,  // floating point present
    parameter bit HAS_VEC = 1'b1  // vector extension present
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire nsac_pkg::nsac_req_t req,
    input wire nsac_pkg::nsac_ctx_t ctx,
    output logic [31:0] rdata,
    output logic rvalid,
    output logic undef,
    input wire logic aux_wr,
    input wire logic [31:0] aux_wdata,
    input wire logic [31:0] aux_cur,
    output logic aux_wr_en,
    output logic [31:0] aux_wr_mask,
    input wire logic l2_wr,
    input wire logic [31:0] l2_wdata,
    input wire logic [31:0] l2_cur,
    output logic l2_wr_en,
    output logic [31:0] l2_wr_mask,
    input wire logic cpa_wr,
    input wire logic [31:0] cpa_cur,
    output logic cpa_wr_en,
    output logic [31:0] cpa_wr_mask,
    output logic [31:0] cpa_view,
    input wire logic [3:0] cp_num,
    input wire logic cp_access,
    output logic cp_undef
);
    nsac_pkg::nsac_state_t s_q; // registered state
    nsac_pkg::nsac_state_t s_d; // next state
    logic nonsec;               // effective nonsecure state
    logic [31:0] ctl_view;      // register as read
    logic [31:0] wmask;         // bits software may write
    logic hit;                  // request addresses this register

    // the guard outputs below are combinational on purpose: the
    // neighbouring registers apply them in the same cycle as their
    // own write strobe, so a registered guard would lag one write
    // behind a change of this register or of the security state.
    // the price is a longer path from ctx to the neighbours' enables.
    //
    // only the security state decides which restrictions apply;
    // privilege matters for access to this register alone, since the
    // neighbours run their own privilege checks.
    //
    // clock enable freezes the stored contents and the read answer,
    // while the guards keep following ctx and the frozen contents.

    // monitor mode is always secure
    assign nonsec = ctx.ns_bit & ~ctx.monitor;
    assign hit = req.valid && req.opc1 == `NSAC_OPC1 && req.crn == `NSAC_CRN
        && req.crm == `NSAC_CRM && req.opc2 == `NSAC_OPC2;

    // configuration shapes what is stored and what reads back
    always_comb begin
        wmask = `NSAC_WMASK;
        ctl_view = s_q.ctl & `NSAC_WMASK;
        if (HAS_FP && !HAS_VEC) begin
            // fixed ones, writes ignored
            wmask[`NSAC_BIT_VEC] = 1'b0;
            wmask[`NSAC_BIT_UPR] = 1'b0;
            ctl_view[`NSAC_BIT_VEC] = 1'b1;
            ctl_view[`NSAC_BIT_UPR] = 1'b1;
        end else if (!HAS_FP) begin
            // unknown bits are given zero for determinism
            wmask[`NSAC_BIT_VEC] = 1'b0;
            wmask[`NSAC_BIT_UPR] = 1'b0;
            wmask[`NSAC_BIT_COPROC_ELEVEN_NS_ENABLE] = 1'b0;
            wmask[`NSAC_BIT_COPROC_TEN_NS_ENABLE] = 1'b0;
            ctl_view[`NSAC_BIT_VEC] = 1'b0;
            ctl_view[`NSAC_BIT_UPR] = 1'b0;
            ctl_view[`NSAC_BIT_COPROC_ELEVEN_NS_ENABLE] = 1'b0;
            ctl_view[`NSAC_BIT_COPROC_TEN_NS_ENABLE] = 1'b0;
        end
    end

    // next state: register access with privilege checks
    // level zero is refused first, whatever the security state;
    // a nonsecure write is refused and leaves the contents alone;
    // reserved bits never reach storage, so they read zero later
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.undef = 1'b0;
        if (hit) begin
            if (ctx.priv == 2'h0 && !ctx.monitor) begin
                s_d.undef = 1'b1;
            end else if (req.write) begin
                if (nonsec) begin
                    s_d.undef = 1'b1;
                end else begin
                    s_d.ctl = req.wdata & wmask;
                end
            end else begin
                s_d.rdata = ctl_view;
                s_d.rvalid = 1'b1;
            end
        end
    end

    // guard on the auxiliary control register
    always_comb begin
        aux_wr_en = aux_wr;
        aux_wr_mask = 32'hFFFFFFFF;
        if (nonsec) begin
            aux_wr_mask = 32'h00000000;
            if (ctl_view[`NSAC_BIT_COH]) begin
                aux_wr_mask[`NSAC_AUX_COH_BIT] = 1'b1;
            end
            aux_wr_en = aux_wr && ctl_view[`NSAC_BIT_COH];
        end
    end

    // guard on the l2 extended control register
    always_comb begin
        l2_wr_en = l2_wr;
        l2_wr_mask = 32'hFFFFFFFF;
        if (nonsec) begin
            l2_wr_mask = 32'h00000000;
            if (ctl_view[`NSAC_BIT_L2E]) begin
                l2_wr_mask[`NSAC_L2_ERR_BIT] = 1'b1;
            end
            l2_wr_en = l2_wr && ctl_view[`NSAC_BIT_L2E];
        end
    end

    // guard and read view of the coprocessor access register
    always_comb begin
        cpa_wr_en = cpa_wr;
        cpa_wr_mask = 32'hFFFFFFFF;
        cpa_view = cpa_cur;
        if (nonsec) begin
            if (ctl_view[`NSAC_BIT_VEC]) begin
                cpa_view[`NSAC_CPA_VEC_BIT] = 1'b1;
                cpa_wr_mask[`NSAC_CPA_VEC_BIT] = 1'b0;
            end
            if (ctl_view[`NSAC_BIT_UPR]) begin
                cpa_view[`NSAC_CPA_UPR_BIT] = 1'b1;
                cpa_wr_mask[`NSAC_CPA_UPR_BIT] = 1'b0;
            end
            if (!ctl_view[`NSAC_BIT_COPROC_TEN_NS_ENABLE]) begin
                cpa_view[`NSAC_CPA_COPROC_TEN_NS_ENABLE_LSB +: 2] = 2'h0;
                cpa_wr_mask[`NSAC_CPA_COPROC_TEN_NS_ENABLE_LSB +: 2] = 2'h0;
            end
            if (!ctl_view[`NSAC_BIT_COPROC_ELEVEN_NS_ENABLE]) begin
                cpa_view[`NSAC_CPA_COPROC_ELEVEN_NS_ENABLE_LSB +: 2] = 2'h0;
                cpa_wr_mask[`NSAC_CPA_COPROC_ELEVEN_NS_ENABLE_LSB +: 2] = 2'h0;
            end
        end
    end

    // slot access check; mismatched enables are left per slot
    // software keeps both enables equal; when it does not, each slot
    // simply follows its own bit, which is one legal outcome of the
    // unpredictable case and costs no extra logic
    // secure accesses never reach the refusal branch at all
    always_comb begin
        cp_undef = 1'b0;
        if (cp_access && nonsec) begin
            if (cp_num == 4'hB && !ctl_view[`NSAC_BIT_COPROC_ELEVEN_NS_ENABLE]) begin
                cp_undef = 1'b1;
            end else if (cp_num == 4'hA && !ctl_view[`NSAC_BIT_COPROC_TEN_NS_ENABLE]) begin
                cp_undef = 1'b1;
            end
            // enabled slots pass in either state
        end
    end

    // state register, frozen while clock enable low
    // reset is synchronous and takes effect on any rising edge, whatever the clock enable
    // read data is cleared too, so the first read shows no stale value
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctl <= `NSAC_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // answers come straight from flip-flops, right after the taking edge
    assign rdata = s_q.rdata;
    assign rvalid = s_q.rvalid;
    assign undef = s_q.undef;
endmodule : nsac_top
`default_nettype wire

// file: dv/nsac_monitor.sv
// checker for the non-secure access control block
// assumes binding to nsac_top; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module nsac_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire nsac_pkg::nsac_req_t req,
    input wire nsac_pkg::nsac_ctx_t ctx,
    input wire logic rvalid,
    input wire logic undef,
    input wire logic aux_wr,
    input wire logic aux_wr_en,
    input wire logic [31:0] aux_wr_mask,
    input wire logic l2_wr,
    input wire logic l2_wr_en,
    input wire logic [31:0] l2_wr_mask,
    input wire logic [31:0] cpa_view,
    input wire logic [3:0] cp_num,
    input wire logic cp_access,
    input wire logic cp_undef
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // request taken at this edge
    wire logic hit = clk_en & req.valid & (req.opc1 == 3'h0) & (req.crn == 4'h1)
        & (req.crm == 4'h1) & (req.opc2 == 3'h2);
    // monitor mode is secure whatever the ns bit says
    wire logic ns = ctx.ns_bit & ~ctx.monitor;
    wire logic pl0 = (ctx.priv == 2'h0) & ~ctx.monitor;
    AST_PL0_REFUSED: assert property (hit && pl0 |=> undef && !rvalid)
        else $error("level zero access not refused");
    AST_NS_WRITE_REFUSED: assert property (hit && req.write && ns |=> undef)
        else $error("nonsecure write not refused");
    AST_READ_ANSWERED: assert property (hit && !req.write && !pl0 |=> rvalid && !undef)
        else $error("read not answered");
    AST_SECURE_WRITE_QUIET: assert property (hit && req.write && !ns && !pl0 |=> !undef)
        else $error("secure write refused");
    AST_NS_AUX_ONLY_COH: assert property (ns && aux_wr && aux_wr_en |-> aux_wr_mask == 32'h40)
        else $error("aux mask wider than coherency bit");
    AST_NS_L2_ONLY_ERR: assert property (ns && l2_wr && l2_wr_en |-> l2_wr_mask == 32'h20000000)
        else $error("l2 mask wider than error bit");
    AST_SECURE_GUARDS_OPEN: assert property (!ns && aux_wr && l2_wr |-> aux_wr_en && l2_wr_en
        && (aux_wr_mask & l2_wr_mask) == 32'hFFFFFFFF)
        else $error("secure guarded write restricted");
    AST_SECURE_SLOTS_OPEN: assert property (!ns && cp_access |-> !cp_undef)
        else $error("secure slot access refused");
    AST_SLOT_TEN_DENIED: assert property (ns && cp_access && cp_num == 4'hA && cp_undef
        |-> cpa_view[21:20] == 2'h0)
        else $error("denied slot field not zero");
endmodule : nsac_monitor
bind nsac_top nsac_monitor nsac_monitor_inst (.clock, .rst, .clk_en, .req, .ctx, .rvalid, .undef,
    .aux_wr, .aux_wr_en, .aux_wr_mask, .l2_wr, .l2_wr_en, .l2_wr_mask, .cpa_view, .cp_num,
    .cp_access, .cp_undef);
`default_nettype wire

// file: dv/test_nonsecure_access_control.sv
// bench for the non-secure access control block
// assumes nsac_top with floating point and vector present
`timescale 1ns/10ps
`default_nettype none
module test_nonsecure_access_control;
    logic clock = 1'b0; // 50 ns period
    logic rst = 1'b1; // synchronous reset
    logic clk_en = 1'b1; // state advances except while the test holds it low
    nsac_pkg::nsac_req_t req = '0;
    nsac_pkg::nsac_ctx_t ctx = '0;
    logic aux_wr = 1'b0, l2_wr = 1'b0, cpa_wr = 1'b0, cp_access = 1'b0;
    logic [3:0] cp_num = 4'hA;
    logic [31:0] cpa_cur = 32'h0;
    logic [31:0] rdata, aux_wr_mask, l2_wr_mask, cpa_wr_mask, cpa_view;
    logic rvalid, undef, aux_wr_en, l2_wr_en, cpa_wr_en, cp_undef;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0; // hang guard
    nsac_top nsac_top_inst (.clock, .rst, .clk_en, .req, .ctx, .rdata, .rvalid, .undef, .aux_wr,
        .aux_wdata(32'hFFFFFFFF), .aux_cur(32'h0), .aux_wr_en, .aux_wr_mask, .l2_wr,
        .l2_wdata(32'hFFFFFFFF), .l2_cur(32'h0), .l2_wr_en, .l2_wr_mask, .cpa_wr, .cpa_cur,
        .cpa_wr_en, .cpa_wr_mask, .cpa_view, .cp_num, .cp_access, .cp_undef);
    initial forever #25 clock = ~clock;
    // the tests need a few dozen cycles; far more means a hang
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one move; ans is {undef, rvalid} expected one cycle later
    task automatic acc(input logic w, input logic [31:0] d, input logic [2:0] o2,
        input logic [1:0] ans, input logic [31:0] er);
        @(posedge clock);
        req <= '{1'b1, w, 3'h0, 4'h1, 4'h1, o2, d};
        {aux_wr, l2_wr, cpa_wr, cp_access} <= 4'h0;
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        chk("answer", {30'h0, ans}, {30'h0, undef, rvalid});
        if (ans == 2'h1) chk("rdata", er, rdata);
    endtask : acc
    // context plus guarded write attempts; comb outputs settle after #1
    task automatic drive(input logic [1:0] p, input logic m, input logic n,
        input logic [31:0] cur, input logic [3:0] slot);
        @(posedge clock);
        ctx <= '{p, m, n};
        {aux_wr, l2_wr, cpa_wr, cp_access} <= 4'hF;
        cpa_cur <= cur;
        cp_num <= slot;
        #1;
    endtask : drive
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        // reset state as seen from nonsecure levels one and two and from secure level zero
        drive(2'h1, 1'b0, 1'b1, 32'h00F00000, 4'hA);
        chk("aux_wr_en", 32'h0, {31'h0, aux_wr_en});
        chk("l2_wr_en", 32'h0, {31'h0, l2_wr_en});
        chk("cp_undef", 32'h1, {31'h0, cp_undef});
        chk("cpa_view", 32'h0, cpa_view);
        chk("cpa_mask", 32'h0, {28'h0, cpa_wr_mask[23:20]});
        drive(2'h1, 1'b0, 1'b1, 32'h00F00000, 4'hB);
        chk("cp_undef", 32'h1, {31'h0, cp_undef});
        acc(1'b0, 32'h0, 3'h2, 2'h1, 32'h0);
        acc(1'b1, 32'hFFFFFFFF, 3'h2, 2'h2, 32'h0);
        drive(2'h2, 1'b0, 1'b1, 32'h0, 4'hA);
        acc(1'b0, 32'h0, 3'h2, 2'h1, 32'h0);
        drive(2'h0, 1'b0, 1'b0, 32'h0, 4'hA);
        acc(1'b0, 32'h0, 3'h2, 2'h2, 32'h0);
        $display("test reset_state done");
        // secure level one sets every writable bit; other encodings are not this register
        drive(2'h1, 1'b0, 1'b0, 32'h0, 4'hA);
        chk("aux_mask", 32'hFFFFFFFF, aux_wr_mask);
        acc(1'b1, 32'hFFFFFFFF, 3'h2, 2'h0, 32'h0);
        acc(1'b0, 32'h0, 3'h2, 2'h1, 32'h0006CC00);
        @(posedge clock) clk_en <= 1'b0;
        acc(1'b1, 32'h0, 3'h2, 2'h0, 32'h0);
        @(posedge clock) clk_en <= 1'b1;
        acc(1'b0, 32'h0, 3'h2, 2'h1, 32'h0006CC00);
        acc(1'b0, 32'h0, 3'h0, 2'h0, 32'h0);
        drive(2'h1, 1'b0, 1'b1, 32'h00F00000, 4'hA);
        chk("aux_wr_en", 32'h1, {31'h0, aux_wr_en});
        chk("aux_mask", 32'h00000040, aux_wr_mask);
        chk("l2_mask", 32'h20000000, l2_wr_mask);
        chk("cpa_view", 32'hC0F00000, cpa_view);
        chk("cpa_mask30", 32'h0, {31'h0, cpa_wr_mask[30]});
        chk("cp_undef", 32'h0, {31'h0, cp_undef});
        chk("cpa_wr_en", 32'h1, {31'h0, cpa_wr_en});
        chk("l2_wr_en", 32'h1, {31'h0, l2_wr_en});
        drive(2'h1, 1'b1, 1'b1, 32'h00F00000, 4'hB);
        chk("cpa_view", 32'h00F00000, cpa_view);
        $display("test all_enabled done");
        summarize();
    end
endmodule : test_nonsecure_access_control
`default_nettype wire
